// [hdl/pmc_regs.svh]
// Purpose : command codes, field positions, reset values and timing counts
// Assumes : included by the supervisor package users only
// Notes   : definitions only
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH
// ****************************************
// command codes
// ****************************************
`define PMC_OPERATION      8'h01
`define PMC_EN_CFG         8'h02
`define PMC_CLEAR_FAULTS   8'h03
`define PMC_STORE_CFG      8'h11
`define PMC_VOUT_OV_LIM    8'h40
`define PMC_VOUT_OV_ACT    8'h41
`define PMC_VOUT_OV_WARN   8'h42
`define PMC_VOUT_UV_WARN   8'h43
`define PMC_VOUT_UV_LIM    8'h44
`define PMC_VOUT_UV_ACT    8'h45
`define PMC_IOUT_OC_LIM    8'h46
`define PMC_IOUT_OC_ACT    8'h47
`define PMC_IOUT_OC_WARN   8'h4A
`define PMC_OT_ACT         8'h50
`define PMC_OT_WARN        8'h51
`define PMC_VIN_OV_LIM     8'h55
`define PMC_VIN_OV_ACT     8'h56
`define PMC_VIN_UV_LIM     8'h58
`define PMC_STAT_BYTE      8'h78
`define PMC_STAT_WORD      8'h79
`define PMC_STAT_VOUT      8'h7A
`define PMC_STAT_IOUT      8'h7B
`define PMC_STAT_INPUT     8'h7C
`define PMC_STAT_TEMP      8'h7D
`define PMC_PG1_LIM        8'hE0
`define PMC_PG2_LIM        8'hE1
`define PMC_VOUT_SET       8'hE2
// ****************************************
// fields
// ****************************************
`define PMC_OP_ON          7
`define PMC_CFG_BUS        3
`define PMC_CFG_PIN        2
`define PMC_CFG_POL        1
`define PMC_ACT_MODE_HI    7
`define PMC_ACT_MODE_LO    6
`define PMC_ACT_ALERT      5
// ****************************************
// reset values
// ****************************************
`define PMC_OP_RST         8'h00
`define PMC_CFG_RST        8'h0C
`define PMC_OC_ACT_RST     8'hE0
`define PMC_ACT_RST        8'hA0
`define PMC_LIM_RST        16'hFFFF
`define PMC_LO_RST         16'h0000
`define PMC_OT_WARN_RST    16'h006E
// ****************************************
// thresholds and timing
// ****************************************
`define PMC_OT_LIMIT_C     125
`define PMC_OT_RESTART_PCT 97
`define PMC_PREBIAS_PCT    85
`define PMC_HICCUP_MS      10
`define PMC_MCLK_MHZ       200
`endif

// [hdl/pmc_pkg.sv]
// Purpose : types of the power module supervisor
// Assumes : nothing
// Notes   : state is one packed struct
package pmc_pkg;
	typedef enum logic [1:0] {PMC_OFF, PMC_RUN, PMC_HICCUP, PMC_LATCH} pmc_fsm_t;
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  code;
		logic [15:0] wdata;
	} pmc_cmd_t;
	typedef struct packed {
		logic [15:0] vout1;
		logic [15:0] vout2;
		logic [15:0] iout;
		logic [15:0] vin;
		logic [15:0] temp;
		logic        sw_cycle;
	} pmc_tel_t;
	typedef struct packed {
		pmc_fsm_t    fsm;
		logic [31:0] hic_cnt;
		logic        boot;
		logic        pin_s1;
		logic        pin_s2;
		logic [7:0]  op;
		logic [7:0]  cfg;
		logic [15:0] vov_lim, vov_warn, vuv_warn, vuv_lim, oc_lim, oc_warn;
		logic [15:0] ot_warn, vin_ov_lim, vin_uv_lim, pg1_lim, pg2_lim, vset;
		logic [7:0]  vov_act, vuv_act, oc_act, ot_act, vin_act;
		logic [7:0]  s_vout, s_iout, s_input, s_temp;
		logic        ot_hold;
		logic        on;
		logic [1:0]  pg_oe;
		logic        alert_oe;
		logic [15:0] rdata;
		logic        rvalid;
		logic        nvm_wr;
		logic [7:0]  nvm_wdata;
	} pmc_state_t;
endpackage

// [hdl/pmc_supervisor.sv]
// Purpose : on/off control and fault supervision of a point-of-load module
// Assumes : telemetry and command strobes arrive on mclk; enable pin is asynchronous
// Notes   : command framing and nonvolatile storage live outside this block
`timescale 1ns/10ps
`include "pmc_regs.svh"

// What this block does
// - pin-only mode ignores bus on/off
// - bus-only mode ignores enable pin
// - combined mode: pin or bus turns on
// - reset configuration uses both sources
// - source selection stored and reloaded from nonvolatile
// - enable pin active low by default
// - bus setting selects active-high pin
// - operation command switches output when permitted
// - source/polarity taken from configuration command
// - overcurrent defaults to endless hiccup, changeable
// - overcurrent checked each switching cycle against limit
// - thermal shutdown 125C, restart at 97%
// - start only if prebias 15% below setpoint
// - two open-drain power-good outputs, programmable thresholds
// - input over/under voltage inhibits operation
// - output voltage limits and actions programmable
// - overcurrent warning limit and fault action programmable
// - overtemperature action and warning limit programmable
// - alert line asserted by alert-enabled faults
// - status readable at six status codes
// - overtemperature warning at programmable threshold
module pmc_supervisor
	import pmc_pkg::*;
#(
	parameter int HICCUP_CYCLES = `PMC_HICCUP_MS * 1000 * `PMC_MCLK_MHZ
) (
	input  wire logic     mclk,
	input  wire logic     rst_n,
	input  wire logic     en_pin,
	input  wire pmc_cmd_t cmd,
	input  wire pmc_tel_t tel,
	input  wire logic     nvm_valid,
	input  wire logic [7:0] nvm_cfg,
	output logic          pwr_en,
	output logic          power_good_loop1_oe,
	output logic          power_good_loop2_oe,
	output logic          alert_oe,
	output logic [15:0]   rdata,
	output logic          rvalid,
	output logic          nvm_wr,
	output logic [7:0]    nvm_wdata
);
	localparam logic [31:0] HIC_LOAD = 32'(HICCUP_CYCLES);

	pmc_state_t st;
	pmc_state_t next_st;

	// ****************************************
	// fault detection
	// ****************************************
	logic        pin_act, bus_act, want_on, vin_bad, prebias_ok;
	logic        f_vov, f_vuv, f_oc, f_ot, w_vov, w_vuv, w_oc, w_ot;
	logic        sd_hit, sd_hiccup, sd_latch;
	logic [1:0]  pg_hit;
	logic [31:0] temp_x100, vout_x100, vset_x85;

	// polarity bit set means the pin is active high
	assign pin_act   = st.pin_s2 ^ ~st.cfg[`PMC_CFG_POL];
	assign bus_act   = st.op[`PMC_OP_ON];
	// each source only counts when its enable bit says so; both set gives either
	assign want_on   = (st.cfg[`PMC_CFG_PIN] & pin_act)
	                 | (st.cfg[`PMC_CFG_BUS] & bus_act);
	assign vin_bad   = (tel.vin > st.vin_ov_lim) | (tel.vin < st.vin_uv_lim);
	assign f_vov     = st.on & (tel.vout1 > st.vov_lim);
	assign f_vuv     = st.on & (tel.vout1 < st.vuv_lim);
	assign w_vov     = tel.vout1 > st.vov_warn;
	assign w_vuv     = st.on & (tel.vout1 < st.vuv_warn);
	// current sampled once per switching cycle, not continuously
	assign f_oc      = st.on & tel.sw_cycle & (tel.iout > st.oc_lim);
	assign w_oc      = tel.iout > st.oc_warn;
	assign f_ot      = tel.temp > 16'(`PMC_OT_LIMIT_C);
	assign w_ot      = tel.temp > st.ot_warn;
	assign temp_x100 = 32'(tel.temp) * 32'd100;
	assign vout_x100 = 32'(tel.vout1) * 32'd100;
	assign vset_x85  = 32'(st.vset) * 32'(`PMC_PREBIAS_PCT);
	assign prebias_ok = vout_x100 <= vset_x85;

	// which shutdown faults fire now, and whether any asks for hiccup or latch
	always_comb begin
		logic [3:0] hit;
		logic [7:0] act [4];
		hit    = {f_vov, f_vuv, f_oc, f_ot};
		act[3] = st.vov_act;
		act[2] = st.vuv_act;
		act[1] = st.oc_act;
		act[0] = st.ot_act;
		sd_hit    = 1'b0;
		sd_hiccup = 1'b0;
		sd_latch  = 1'b0;
		for (int i = 0; i < 4; i++) begin
			if (hit[i] && act[i][7:6] != 2'b00) begin
				sd_hit = 1'b1;
				if (act[i][7:6] == 2'b11) begin
					sd_hiccup = 1'b1;
				end
				if (act[i][7:6] == 2'b01) begin
					sd_latch = 1'b1;
				end
			end
		end
	end

	// power good per loop: released once the loop rises above its threshold while on
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_pg
			logic [15:0] v;
			logic [15:0] lim;
			assign v   = (g == 0) ? tel.vout1 : tel.vout2;
			assign lim = (g == 0) ? st.pg1_lim : st.pg2_lim;
			assign pg_hit[g] = st.on & (v > lim);
		end
	endgenerate

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_st        = st;
		next_st.pin_s1 = en_pin;
		next_st.pin_s2 = st.pin_s1;
		next_st.boot   = 1'b0;
		next_st.rvalid = 1'b0;
		next_st.nvm_wr = 1'b0;
		// reload the stored source selection once after reset
		if (st.boot && nvm_valid) begin
			next_st.cfg = nvm_cfg;
		end
		// thermal hold clears only once cooled to the restart fraction
		if (f_ot) begin
			next_st.ot_hold = 1'b1;
		end else if (temp_x100 <= 32'(`PMC_OT_LIMIT_C * `PMC_OT_RESTART_PCT)) begin
			next_st.ot_hold = 1'b0;
		end

		// command writes
		if (cmd.wr) begin
			unique case (cmd.code)
				`PMC_OPERATION:    next_st.op         = cmd.wdata[7:0];
				`PMC_EN_CFG:       next_st.cfg        = cmd.wdata[7:0];
				`PMC_VOUT_OV_LIM:  next_st.vov_lim    = cmd.wdata;
				`PMC_VOUT_OV_ACT:  next_st.vov_act    = cmd.wdata[7:0];
				`PMC_VOUT_OV_WARN: next_st.vov_warn   = cmd.wdata;
				`PMC_VOUT_UV_WARN: next_st.vuv_warn   = cmd.wdata;
				`PMC_VOUT_UV_LIM:  next_st.vuv_lim    = cmd.wdata;
				`PMC_VOUT_UV_ACT:  next_st.vuv_act    = cmd.wdata[7:0];
				`PMC_IOUT_OC_LIM:  next_st.oc_lim     = cmd.wdata;
				`PMC_IOUT_OC_ACT:  next_st.oc_act     = cmd.wdata[7:0];
				`PMC_IOUT_OC_WARN: next_st.oc_warn    = cmd.wdata;
				`PMC_OT_ACT:       next_st.ot_act     = cmd.wdata[7:0];
				`PMC_OT_WARN:      next_st.ot_warn    = cmd.wdata;
				`PMC_VIN_OV_LIM:   next_st.vin_ov_lim = cmd.wdata;
				`PMC_VIN_OV_ACT:   next_st.vin_act    = cmd.wdata[7:0];
				`PMC_VIN_UV_LIM:   next_st.vin_uv_lim = cmd.wdata;
				`PMC_PG1_LIM:      next_st.pg1_lim    = cmd.wdata;
				`PMC_PG2_LIM:      next_st.pg2_lim    = cmd.wdata;
				`PMC_VOUT_SET:     next_st.vset       = cmd.wdata;
				`PMC_CLEAR_FAULTS: begin
					next_st.s_vout  = 8'h00;
					next_st.s_iout  = 8'h00;
					next_st.s_input = 8'h00;
					next_st.s_temp  = 8'h00;
				end
				`PMC_STORE_CFG: begin
					next_st.nvm_wr    = 1'b1;
					next_st.nvm_wdata = st.cfg;
				end
				default: ;
			endcase
		end

		// sticky status after the clear so that a new event wins
		next_st.s_vout  = next_st.s_vout  | {f_vov, w_vov, w_vuv, f_vuv, 4'h0};
		next_st.s_iout  = next_st.s_iout  | {f_oc, 1'b0, w_oc, 5'h00};
		next_st.s_input = next_st.s_input
		                | {tel.vin > st.vin_ov_lim, 2'b00, tel.vin < st.vin_uv_lim, 4'h0};
		next_st.s_temp  = next_st.s_temp  | {f_ot, w_ot, 6'h00};

		// command reads, unmapped codes answer zero
		if (cmd.rd) begin
			next_st.rvalid = 1'b1;
			unique case (cmd.code)
				`PMC_OPERATION:    next_st.rdata = {8'h00, st.op};
				`PMC_EN_CFG:       next_st.rdata = {8'h00, st.cfg};
				`PMC_VOUT_OV_LIM:  next_st.rdata = st.vov_lim;
				`PMC_VOUT_OV_ACT:  next_st.rdata = {8'h00, st.vov_act};
				`PMC_VOUT_OV_WARN: next_st.rdata = st.vov_warn;
				`PMC_VOUT_UV_WARN: next_st.rdata = st.vuv_warn;
				`PMC_VOUT_UV_LIM:  next_st.rdata = st.vuv_lim;
				`PMC_VOUT_UV_ACT:  next_st.rdata = {8'h00, st.vuv_act};
				`PMC_IOUT_OC_LIM:  next_st.rdata = st.oc_lim;
				`PMC_IOUT_OC_ACT:  next_st.rdata = {8'h00, st.oc_act};
				`PMC_IOUT_OC_WARN: next_st.rdata = st.oc_warn;
				`PMC_OT_ACT:       next_st.rdata = {8'h00, st.ot_act};
				`PMC_OT_WARN:      next_st.rdata = st.ot_warn;
				`PMC_VIN_OV_LIM:   next_st.rdata = st.vin_ov_lim;
				`PMC_VIN_OV_ACT:   next_st.rdata = {8'h00, st.vin_act};
				`PMC_VIN_UV_LIM:   next_st.rdata = st.vin_uv_lim;
				`PMC_PG1_LIM:      next_st.rdata = st.pg1_lim;
				`PMC_PG2_LIM:      next_st.rdata = st.pg2_lim;
				`PMC_VOUT_SET:     next_st.rdata = st.vset;
				`PMC_STAT_BYTE:    next_st.rdata = {8'h00, 1'b0, ~st.on, st.s_vout[7],
				                       st.s_iout[7], st.s_input[4], |st.s_temp, 2'b00};
				`PMC_STAT_WORD:    next_st.rdata = {|st.s_vout, |st.s_iout, |st.s_input,
				                       1'b0, ~st.pg_oe[0] == 1'b0, 3'b000, 1'b0, ~st.on,
				                       st.s_vout[7], st.s_iout[7], st.s_input[4],
				                       |st.s_temp, 2'b00};
				`PMC_STAT_VOUT:    next_st.rdata = {8'h00, st.s_vout};
				`PMC_STAT_IOUT:    next_st.rdata = {8'h00, st.s_iout};
				`PMC_STAT_INPUT:   next_st.rdata = {8'h00, st.s_input};
				`PMC_STAT_TEMP:    next_st.rdata = {8'h00, st.s_temp};
				default:           next_st.rdata = 16'h0000;
			endcase
		end

		// on/off sequencing; faults take priority over any request
		unique case (st.fsm)
			PMC_OFF: begin
				if (want_on && !vin_bad && !st.ot_hold && prebias_ok) begin
					next_st.fsm = PMC_RUN;
				end
			end
			PMC_RUN: begin
				if (sd_hit && sd_hiccup) begin
					next_st.fsm     = PMC_HICCUP;
					next_st.hic_cnt = HIC_LOAD;
				end else if (sd_hit && sd_latch) begin
					next_st.fsm = PMC_LATCH;
				end else if (sd_hit || !want_on || vin_bad || st.ot_hold) begin
					next_st.fsm = PMC_OFF;
				end
			end
			PMC_HICCUP: begin
				// retry is a fresh start through the off state
				if (st.hic_cnt <= 32'd1) begin
					next_st.fsm = PMC_OFF;
				end else begin
					next_st.hic_cnt = st.hic_cnt - 32'd1;
				end
			end
			PMC_LATCH: begin
				// latched off until the request is withdrawn
				if (!want_on) begin
					next_st.fsm = PMC_OFF;
				end
			end
		endcase
		next_st.on = next_st.fsm == PMC_RUN;

		// open-drain drives low while not good; alert follows enabled sticky faults
		next_st.pg_oe    = ~pg_hit;
		next_st.alert_oe = (next_st.s_vout[7] & st.vov_act[`PMC_ACT_ALERT])
		                 | (next_st.s_vout[4] & st.vuv_act[`PMC_ACT_ALERT])
		                 | (next_st.s_iout[7] & st.oc_act[`PMC_ACT_ALERT])
		                 | (next_st.s_temp[7] & st.ot_act[`PMC_ACT_ALERT])
		                 | ((next_st.s_input[7] | next_st.s_input[4])
		                    & st.vin_act[`PMC_ACT_ALERT]);
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st            <= '0;
			st.fsm        <= PMC_OFF;
			st.boot       <= 1'b1;
			st.pin_s1     <= 1'b1;
			st.pin_s2     <= 1'b1;
			st.op         <= `PMC_OP_RST;
			st.cfg        <= `PMC_CFG_RST;
			st.vov_lim    <= `PMC_LIM_RST;
			st.vov_warn   <= `PMC_LIM_RST;
			st.vuv_warn   <= `PMC_LO_RST;
			st.vuv_lim    <= `PMC_LO_RST;
			st.oc_lim     <= `PMC_LIM_RST;
			st.oc_warn    <= `PMC_LIM_RST;
			st.ot_warn    <= `PMC_OT_WARN_RST;
			st.vin_ov_lim <= `PMC_LIM_RST;
			st.vin_uv_lim <= `PMC_LO_RST;
			st.vov_act    <= `PMC_ACT_RST;
			st.vuv_act    <= `PMC_ACT_RST;
			st.oc_act     <= `PMC_OC_ACT_RST;
			st.ot_act     <= `PMC_ACT_RST;
			st.vin_act    <= `PMC_ACT_RST;
			st.pg_oe      <= 2'b11;
		end else begin
			st <= next_st;
		end
	end

	assign pwr_en              = st.on;
	assign power_good_loop1_oe = st.pg_oe[0];
	assign power_good_loop2_oe = st.pg_oe[1];
	assign alert_oe            = st.alert_oe;
	assign rdata               = st.rdata;
	assign rvalid              = st.rvalid;
	assign nvm_wr              = st.nvm_wr;
	assign nvm_wdata           = st.nvm_wdata;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	property p_pin_only;
		(st.cfg[3:2] == 2'b01 && !pin_act) |=> !pwr_en;
	endproperty
	a_pin_only: assert property (p_pin_only) else $error("bus turned output on");

	property p_bus_only;
		(st.cfg[3:2] == 2'b10 && !bus_act) |=> !pwr_en;
	endproperty
	a_bus_only: assert property (p_bus_only) else $error("pin turned output on");

	property p_vin_block;
		vin_bad |=> !pwr_en;
	endproperty
	a_vin_block: assert property (p_vin_block) else $error("on with bad input");

	property p_ot_hold;
		st.ot_hold |=> !pwr_en;
	endproperty
	a_ot_hold: assert property (p_ot_hold) else $error("on while too hot");

	property p_hiccup;
		(st.fsm == PMC_RUN && sd_hit && sd_hiccup) |=> !pwr_en [*8];
	endproperty
	a_hiccup: assert property (p_hiccup) else $error("hiccup too short");

	property p_alert;
		(st.s_iout[7] && st.oc_act[`PMC_ACT_ALERT]) |-> alert_oe;
	endproperty
	a_alert: assert property (p_alert) else $error("alert missing");

	property p_pg;
		(!st.on) |=> power_good_loop1_oe && power_good_loop2_oe;
	endproperty
	a_pg: assert property (p_pg) else $error("power good while off");

	property p_prebias;
		(st.fsm == PMC_OFF && !prebias_ok) |=> !pwr_en;
	endproperty
	a_prebias: assert property (p_prebias) else $error("start into high prebias");

	property p_status_rd;
		(cmd.rd && cmd.code == `PMC_STAT_TEMP) |=> rvalid && rdata[7] == $past(st.s_temp[7]);
	endproperty
	a_status_rd: assert property (p_status_rd) else $error("status read wrong");

	c_start:  cover property (st.fsm == PMC_OFF ##1 st.fsm == PMC_RUN);
	c_hiccup: cover property (st.fsm == PMC_HICCUP ##1 st.fsm == PMC_OFF);
	c_latch:  cover property (st.fsm == PMC_LATCH);
	c_ot:     cover property (st.ot_hold ##1 !st.ot_hold);
endmodule // pmc_supervisor

// [verification/pmc_host_model.sv]
// Purpose : host and enable-source model facing the supervisor
// Assumes : strobes are launched 1 ns after a rising edge
// Notes   : the enable pin has a pull-up, so an idle source reads high
`timescale 1ns/10ps
module pmc_host_model
	import pmc_pkg::*;
(
	input  wire logic mclk,
	output pmc_cmd_t  cmd,
	output logic      en_pin
);
	// ****************************************
	// command strobe and enable source
	// ****************************************
	// idle bus, enable source released to the pull-up
	initial begin
		cmd = '0;
		en_pin = 1'b1;
	end
	// one strobe per command; stall models a slow host
	task automatic send(input logic rd, input logic [7:0] code, input logic [15:0] d,
		input int stall);
		repeat (stall + 1) @(posedge mclk);
		#1;
		cmd.rd = rd;
		cmd.wr = !rd;
		cmd.code = code;
		cmd.wdata = d;
		@(posedge mclk);
		#1;
		// released fields show the inverse so stale data cannot pass by luck
		cmd = '{wr: 1'b0, rd: 1'b0, code: ~code, wdata: ~d};
	endtask
	// pin changes just after an edge, like any other request
	task automatic pin(input logic v);
		@(posedge mclk);
		#1;
		en_pin = v;
	endtask
endmodule // pmc_host_model

// [verification/power_module_control_supervisor_tb.sv]
// Purpose : self-checking bench of the power module supervisor
// Assumes : pmc_host_model drives commands and the enable pin
// Notes   : hiccup interval shortened to 20 cycles to keep the run short
`timescale 1ns/10ps
module power_module_control_supervisor_tb import pmc_pkg::*;;
	localparam int HIC = 20;
	logic        mclk;
	logic        rst_n;
	logic        en_pin;
	pmc_cmd_t    cmd;
	pmc_tel_t    tel;
	logic        nvm_valid;
	logic [7:0]  nvm_cfg;
	logic        pwr_en;
	logic        pg1_oe;
	logic        pg2_oe;
	logic        alert_oe;
	logic [15:0] rdata;
	logic        rvalid;
	logic        nvm_wr;
	logic [7:0]  nvm_wdata;
	int          num_errors;
	int          n_compared;
	int          k;
	logic [15:0] d;
	logic [7:0]  m_cfg;
	logic [7:0]  m_op;
	logic        m_pin;
	logic [7:0]  rst_code [9] = '{8'h01, 8'h02, 8'h47, 8'h41, 8'h51, 8'h7D, 8'h40, 8'h44, 8'h30};
	logic [15:0] rst_val [9] = '{16'h0000, 16'h000C, 16'h00E0, 16'h00A0, 16'h006E, 16'h0000,
		16'hFFFF, 16'h0000, 16'h0000};
	logic [7:0]  cfg_tab [5] = '{8'h0C, 8'h04, 8'h08, 8'h06, 8'h0E};
	logic [7:0]  rw_code [14] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47,
		8'h4A, 8'h50, 8'h51, 8'h55, 8'h56, 8'h58};
	logic [13:0] rw_word = 14'b10111010101101;

	// ****************************************
	// clock, partner and design
	// ****************************************
	// free-running 200 MHz clock
	initial mclk = 1'b0;
	always #2.5 mclk = ~mclk;

	pmc_host_model host (.mclk(mclk), .cmd(cmd), .en_pin(en_pin));

	pmc_supervisor #(.HICCUP_CYCLES(HIC)) uut (
		.mclk(mclk), .rst_n(rst_n), .en_pin(en_pin), .cmd(cmd), .tel(tel),
		.nvm_valid(nvm_valid), .nvm_cfg(nvm_cfg), .pwr_en(pwr_en),
		.power_good_loop1_oe(pg1_oe), .power_good_loop2_oe(pg2_oe), .alert_oe(alert_oe),
		.rdata(rdata), .rvalid(rvalid), .nvm_wr(nvm_wr), .nvm_wdata(nvm_wdata));

	// ****************************************
	// helpers
	// ****************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// random stall exercises a slow host
	task automatic wr(input logic [7:0] code, input logic [15:0] v);
		host.send(1'b0, code, v, $urandom_range(2));
	endtask
	// answer pulse stands only in the cycle after the taking edge, just when send returns
	task automatic rd(input logic [7:0] code, input logic [15:0] exp);
		host.send(1'b1, code, 16'h0000, 0);
		check(rvalid, 1'b1);
		check(rdata, exp);
	endtask
	// pin needs two sync edges plus one for the output register
	task automatic settle();
		repeat (4) @(posedge mclk);
		#1;
	endtask
	task automatic sw_pulse();
		tel.sw_cycle = 1'b1;
		@(posedge mclk);
		#1;
		tel.sw_cycle = 1'b0;
	endtask
	task automatic do_reset(input logic v, input logic [7:0] c);
		nvm_valid = v;
		nvm_cfg = c;
		rst_n = 1'b0;
		repeat (5) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		m_cfg = v ? c : 8'h0C;
		m_op = 8'h00;
	endtask
	function automatic logic want();
		return (m_cfg[2] & (m_pin == m_cfg[1])) | (m_cfg[3] & m_op[7]);
	endfunction

	// ****************************************
	// watchdog and main sequence
	// ****************************************
	// far above the few hundred cycles the sequence needs
	initial begin
		#100000;
		num_errors++;
		stop_test();
	end

	initial begin
		num_errors = 0;
		n_compared = 0;
		void'($urandom(15737));
		tel = '0;
		tel.vin = 16'h0800;
		m_pin = 1'b1;
		do_reset(1'b0, 8'h00);
		// reset values, then an unmapped code that must read zero
		for (int i = 0; i < 9; i++)
			rd(rst_code[i], rst_val[i]);
		// source and polarity over random pin and bus requests
		for (int i = 0; i < 20; i++) begin
			m_cfg = cfg_tab[i % 5];
			m_op = $urandom_range(1) ? 8'h80 : 8'h00;
			m_pin = 1'($urandom_range(1));
			wr(8'h02, {8'h00, m_cfg});
			wr(8'h01, {8'h00, m_op});
			host.pin(m_pin);
			settle();
			check(pwr_en, want());
		end
		rd(8'h02, {8'h00, m_cfg});
		// storing the selection raises one request carrying it
		wr(8'h11, 16'h0000);
		k = 0;
		while (nvm_wr !== 1'b1 && k < 8) begin
			@(posedge mclk);
			#1;
			k++;
		end
		check(nvm_wr, 1'b1);
		check(nvm_wdata, m_cfg);
		wr(8'h02, 16'h0008);
		wr(8'h01, 16'h0080);
		settle();
		check(pwr_en, 1'b1);
		// thermal warning, shutdown and restart hysteresis
		tel.temp = 16'h006F;
		settle();
		rd(8'h7D, 16'h0040);
		tel.temp = 16'h007E;
		settle();
		check(pwr_en, 1'b0);
		check(alert_oe, 1'b1);
		rd(8'h7D, 16'h00C0);
		// summary: off and temperature bits, word adds power-not-good
		rd(8'h78, 16'h0044);
		rd(8'h79, 16'h0844);
		tel.temp = 16'h007A;
		settle();
		check(pwr_en, 1'b0);
		tel.temp = 16'h0079;
		settle();
		check(pwr_en, 1'b1);
		tel.temp = 16'h0019;
		wr(8'h03, 16'h0000);
		settle();
		check(alert_oe, 1'b0);
		// input over limit inhibits operation
		wr(8'h55, 16'h1000);
		tel.vin = 16'h2000;
		settle();
		check(pwr_en, 1'b0);
		check(alert_oe, 1'b1);
		rd(8'h7C, 16'h0080);
		tel.vin = 16'h0800;
		wr(8'h03, 16'h0000);
		settle();
		check(pwr_en, 1'b1);
		check(alert_oe, 1'b0);
		// overcurrent counts only on a switching-cycle pulse
		wr(8'h46, 16'h0100);
		tel.iout = 16'h0200;
		settle();
		check(pwr_en, 1'b1);
		sw_pulse();
		tel.iout = 16'h0010;
		repeat (HIC / 2) @(posedge mclk);
		#1;
		check(pwr_en, 1'b0);
		check(alert_oe, 1'b1);
		rd(8'h7B, 16'h0080);
		k = 0;
		while (pwr_en !== 1'b1 && k < 3 * HIC) begin
			@(posedge mclk);
			#1;
			k++;
		end
		check(pwr_en, 1'b1);
		// response set to ignore keeps the output on
		wr(8'h47, 16'h0000);
		tel.iout = 16'h0200;
		sw_pulse();
		settle();
		check(pwr_en, 1'b1);
		tel.iout = 16'h0010;
		wr(8'h03, 16'h0000);
		// power good released above its own threshold while on
		tel.vout1 = 16'h0200;
		wr(8'hE0, 16'h0100);
		settle();
		check(pg1_oe, 1'b0);
		check(pg2_oe, 1'b1);
		wr(8'h01, 16'h0000);
		settle();
		check(pwr_en, 1'b0);
		check(pg1_oe, 1'b1);
		// start into prebias only when far enough below setpoint
		wr(8'hE2, 16'h0100);
		wr(8'h01, 16'h0080);
		settle();
		check(pwr_en, 1'b0);
		tel.vout1 = 16'h00D9;
		settle();
		check(pwr_en, 1'b1);
		// latch response holds off after the cause is gone, until the request drops
		wr(8'h41, 16'h0040);
		wr(8'h40, 16'h0080);
		settle();
		check(pwr_en, 1'b0);
		wr(8'h40, 16'hFFFF);
		settle();
		check(pwr_en, 1'b0);
		check(alert_oe, 1'b0);
		wr(8'h01, 16'h0000);
		wr(8'h01, 16'h0080);
		settle();
		check(pwr_en, 1'b1);
		// limit and action registers read back what was written
		for (int i = 0; i < 14; i++) begin
			d = 16'($urandom_range(16'hFFFF)) & (rw_word[13 - i] ? 16'hFFFF : 16'h00FF);
			wr(rw_code[i], d);
			rd(rw_code[i], d);
		end
		// stored selection is reapplied after a later reset
		do_reset(1'b1, 8'h04);
		rd(8'h02, 16'h0004);
		stop_test();
	end
endmodule // power_module_control_supervisor_tb
